// *** hdl/pond_pkg.sv ***
// Package: register map, field layout and reset values of the pattern output block
package pond_pkg;
	// Register offsets (byte addresses on the register port)
	localparam logic [27:0] POND_ADDR_STAGE_HI = 28'h5FFFFF4;
	localparam logic [27:0] POND_ADDR_STAGE_ALT = 28'h5FFFFF6;
	localparam logic [27:0] POND_ADDR_EN_LOW = 28'h5FFFFF8;
	localparam logic [27:0] POND_ADDR_EN_HIGH = 28'h5FFFFF9;
	localparam logic [27:0] POND_ADDR_TRIG_SEL = 28'h5FFFFFA;
	localparam logic [27:0] POND_ADDR_PORT_DATA = 28'h5FFFFFC;
	// Reset values
	localparam logic [7:0] POND_RST_STAGE = 8'h00;
	localparam logic [7:0] POND_RST_EN = 8'h00;
	localparam logic [7:0] POND_RST_TRIG_SEL = 8'hFF;
	localparam logic [15:0] POND_RST_PORT_DATA = 16'h0000;
	// Reserved bits read back as ones
	localparam logic [3:0] POND_RSVD_NIBBLE = 4'hF;
	localparam logic [7:0] POND_RSVD_BYTE = 8'hFF;
	// Trigger-select field positions (low bit of each 2-bit field)
	localparam int POND_SEL_G3_LSB = 6;
	localparam int POND_SEL_G2_LSB = 4;
	localparam int POND_SEL_G1_LSB = 2;
	localparam int POND_SEL_G0_LSB = 0;
	localparam int POND_GROUPS = 4;
	localparam int POND_GROUP_W = 4;
endpackage

// *** hdl/pond_group_copy.sv ***
// One 4-pin group: trigger selection and enabled copy of staged bits
`timescale 1ns/1ps
module pond_group_copy (
	// Selection
	input wire logic [1:0] sel,
	input wire logic [3:0] cmp_match_a,
	// Data
	input wire logic [3:0] staged,
	input wire logic [3:0] enable,
	input wire logic [3:0] current,
	// Result
	output logic fire,
	output logic [3:0] next_val
);
	// Channel select and per-bit copy
	always_comb
	begin
		// [R17] compare match A only
		fire = cmp_match_a[sel];
		// [R8] disabled bits hold
		next_val = fire ? ((staged & enable) | (current & ~enable)) : current;
	end
endmodule

// *** hdl/pond_top.sv ***
// Top of the timed pattern unit next-data, enable and trigger-select logic
// Contract
// [R1] Upper staging copies to port on match
// [R2] Shared trigger: whole byte at lower address
// [R3] Split trigger: nibbles at two addresses
// [R4] Reserved staging bits read one, ignore writes
// [R5] Upper staging resets to zero, standby keeps
// [R6] Lower enable register gates pins 7-0
// [R7] Upper enable register gates pins 15-8
// [R8] Disabled bit: no copy, pin holds
// [R9] Lower enable resets zero, standby keeps
// [R10] Upper enable resets zero, standby keeps
// [R11] Trigger select resets all ones
// [R12] Bits 7-6 pick group 3 channel
// [R13] Bits 5-4 pick group 2 channel
// [R14] Bits 3-2 pick group 1 channel
// [R15] Bits 1-0 pick group 0 channel
// [R16] Enabled port bits read-only to software
// [R17] Copy on compare match A
// [R18] Split groups copy only on own match
`timescale 1ns/1ps
module pond_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic [27:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Timer compare match A, one bit per channel
	input wire logic [3:0] cmp_match_a,
	// Lower staged data from the neighbouring block
	input wire logic [7:0] lower_staged_bits,
	// Pattern pins
	output logic [7:0] upper_pattern_pins,
	output logic [7:0] lower_pattern_pins
);
	import pond_pkg::*;

	logic rst_meta_q;
	logic rst_sync_q;
	logic [7:0] stage_q;
	logic [7:0] en_low_q;
	logic [7:0] en_high_q;
	logic [7:0] trig_sel_q;
	logic [15:0] port_q;
	logic [15:0] port_d;
	logic [15:0] rdata_d;
	logic [3:0] fire;
	logic [15:0] staged_all;
	logic [15:0] enable_all;
	logic shared_hi;
	logic wr_stage_hi;
	logic wr_stage_alt;

	// Reset release through two flops; async assert only
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_q <= 1'h0;
			rst_sync_q <= 1'h0;
		end
		else
		begin
			rst_meta_q <= 1'h1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// Groups 3 and 2 share one trigger when their selects match
	assign shared_hi = trig_sel_q[POND_SEL_G3_LSB +: 2] == trig_sel_q[POND_SEL_G2_LSB +: 2];
	assign wr_stage_hi = reg_wr && reg_addr == POND_ADDR_STAGE_HI;
	assign wr_stage_alt = reg_wr && reg_addr == POND_ADDR_STAGE_ALT;

	// Upper staging register; no standby input so contents persist
	always_ff @(posedge mclk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			// [R5] reset to zero
			stage_q <= POND_RST_STAGE;
		else if (wr_stage_hi)
		begin
			// [R2] shared layout full byte
			if (shared_hi)
				stage_q <= reg_wdata[7:0];
			else
				// [R3] split: group 3 nibble only
				stage_q[7:4] <= reg_wdata[7:4];
		end
		// [R4] reserved writes dropped
		else if (wr_stage_alt && !shared_hi)
			stage_q[3:0] <= reg_wdata[3:0];
	end

	// Enable registers
	always_ff @(posedge mclk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			// [R9] lower enable reset
			en_low_q <= POND_RST_EN;
			// [R10] upper enable reset
			en_high_q <= POND_RST_EN;
		end
		else if (reg_wr)
		begin
			// [R6] lower enable write
			if (reg_addr == POND_ADDR_EN_LOW)
				en_low_q <= reg_wdata[7:0];
			// [R7] upper enable write
			if (reg_addr == POND_ADDR_EN_HIGH)
				en_high_q <= reg_wdata[7:0];
		end
	end

	// Trigger select register
	always_ff @(posedge mclk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			// [R11] reset to all ones
			trig_sel_q <= POND_RST_TRIG_SEL;
		else if (reg_wr && reg_addr == POND_ADDR_TRIG_SEL)
			trig_sel_q <= reg_wdata[7:0];
	end

	assign staged_all = {stage_q, lower_staged_bits};
	assign enable_all = {en_high_q, en_low_q};

	// One copy unit per group, each on its own selected channel
	for (genvar g = 0; g < POND_GROUPS; g++)
	begin : g_grp
		// [R12] [R13] [R14] [R15] two select bits per group
		// [R18] independent per-group firing
		pond_group_copy u_copy (
			.sel(trig_sel_q[2 * g +: 2]),
			.cmp_match_a(cmp_match_a),
			.staged(staged_all[POND_GROUP_W * g +: POND_GROUP_W]),
			.enable(enable_all[POND_GROUP_W * g +: POND_GROUP_W]),
			.current(port_q[POND_GROUP_W * g +: POND_GROUP_W]),
			.fire(fire[g]),
			.next_val(port_d[POND_GROUP_W * g +: POND_GROUP_W])
		);
	end

	// Port data register: match copy, else software write of free bits
	always_ff @(posedge mclk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			port_q <= POND_RST_PORT_DATA;
		else if (reg_wr && reg_addr == POND_ADDR_PORT_DATA)
			// [R16] enabled bits ignore software; copy wins
			port_q <= (port_d & enable_all) | (reg_wdata & ~enable_all);
		else
			// [R1] staged data copied on match
			port_q <= port_d;
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rdata_d = 16'h0000;
		unique case (reg_addr)
			POND_ADDR_STAGE_HI:
				// [R4] reserved nibble reads ones
				rdata_d[7:0] = shared_hi ? stage_q : {stage_q[7:4], POND_RSVD_NIBBLE};
			POND_ADDR_STAGE_ALT:
				rdata_d[7:0] = shared_hi ? POND_RSVD_BYTE : {POND_RSVD_NIBBLE, stage_q[3:0]};
			POND_ADDR_EN_LOW:
				rdata_d[7:0] = en_low_q;
			POND_ADDR_EN_HIGH:
				rdata_d[7:0] = en_high_q;
			POND_ADDR_TRIG_SEL:
				rdata_d[7:0] = trig_sel_q;
			POND_ADDR_PORT_DATA:
				rdata_d = port_q;
			default:
				rdata_d = 16'h0000;
		endcase
	end

	// Read data registered, valid the cycle after the strobe only
	always_ff @(posedge mclk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
			reg_rdata <= rdata_d;
		else
			reg_rdata <= 16'h0000;
	end

	// Pins straight from the port data flops
	assign upper_pattern_pins = port_q[15:8];
	assign lower_pattern_pins = port_q[7:0];
endmodule

// *** verif/pond_asserts.sv ***
// Port assertions for the pattern output block
`timescale 1ns/1ps
module pond_asserts
	import pond_pkg::*;
(
	// Watched top ports
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [27:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [3:0] cmp_match_a,
	input wire logic [7:0] upper_pattern_pins,
	input wire logic [7:0] lower_pattern_pins
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Port data write is the only other way pins move
	wire pd_wr = reg_wr && reg_addr == POND_ADDR_PORT_DATA;
	property p_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("rdata idle");
	property p_top; reg_rd && reg_addr != POND_ADDR_PORT_DATA |=> reg_rdata[15:8] == 8'h00; endproperty
	a_top: assert property (p_top) else $error("rdata top");
	property p_unmap; reg_rd && reg_addr == 28'h0000000 |=> reg_rdata == 16'h0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped");
	property p_alt; reg_rd && reg_addr == POND_ADDR_STAGE_ALT |=> reg_rdata[7:4] == 4'hF; endproperty
	a_alt: assert property (p_alt) else $error("reserved");
	property p_up; cmp_match_a == 4'h0 && !pd_wr |=> $stable(upper_pattern_pins); endproperty
	a_up: assert property (p_up) else $error("upper moved");
	property p_lo; cmp_match_a == 4'h0 && !pd_wr |=> $stable(lower_pattern_pins); endproperty
	a_lo: assert property (p_lo) else $error("lower moved");
	property p_rst; $rose(rst_n) |-> {upper_pattern_pins, lower_pattern_pins} == 16'h0000;
	endproperty
	a_rst: assert property (p_rst) else $error("reset pins");
	property p_sel; reg_wr && reg_addr == POND_ADDR_TRIG_SEL ##1 !reg_wr ##1 reg_rd &&
		reg_addr == POND_ADDR_TRIG_SEL |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 3); endproperty
	a_sel: assert property (p_sel) else $error("select back");
	c_match: cover property (cmp_match_a != 4'h0);
	c_alt: cover property (reg_rd && reg_addr == POND_ADDR_STAGE_ALT);
	c_pd: cover property (pd_wr);
endmodule
bind pond_top pond_asserts u_chk (.*);

// *** verif/pond_timer_model.sv ***
// Timer stand-in giving compare match A pulses
`timescale 1ns/1ps
module pond_timer_model (
	// Clock, request, match
	input wire logic mclk,
	input wire logic [3:0] req,
	output logic [3:0] cmp_match_a
);
	always_ff @(posedge mclk)
	begin
		cmp_match_a <= req;
	end
endmodule

// *** verif/tb_pond_top.sv ***
// Self-checking bench for the pattern output block
`timescale 1ns/1ps
module tb_pond_top;
	import pond_pkg::*;
	logic mclk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
	logic [27:0] reg_addr = 28'h0000000;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic [3:0] req = 4'h0, cmp_match_a;
	logic [7:0] lower_staged_bits = 8'hA5, upper_pattern_pins, lower_pattern_pins;
	int n_mismatch = 0, comparisons = 0, cyc = 0;
	pond_timer_model tmr (.*);
	pond_top dut (.*);
	// 40 MHz clock, hang guard
	always #12.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_mismatch++;
			give_verdict;
		end
	end
	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One bus cycle; a read compares d with the data one cycle on
	task acc(input logic w, input logic [27:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'h0;
		reg_rd <= 1'h0;
		if (!w)
			#1 chk("rdata", d, reg_rdata);
	endtask
	// Pulse one channel, then check both pin bytes
	task fire(input int ch, input logic [15:0] e);
		@(posedge mclk);
		req <= 4'h1 << ch;
		@(posedge mclk);
		req <= 4'h0;
		@(posedge mclk);
		#1 chk("pins", e, {upper_pattern_pins, lower_pattern_pins});
	endtask
	initial
	begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (3) @(posedge mclk);
		acc(0, POND_ADDR_STAGE_HI, 16'h0000);
		acc(0, POND_ADDR_EN_LOW, 16'h0000);
		acc(0, POND_ADDR_EN_HIGH, 16'h0000);
		acc(0, POND_ADDR_TRIG_SEL, 16'h00FF);
		acc(0, POND_ADDR_STAGE_ALT, 16'h00FF);
		acc(0, 28'h0000000, 16'h0000);
		acc(1, POND_ADDR_STAGE_HI, 16'h00A5);
		acc(1, POND_ADDR_EN_HIGH, 16'h00FF);
		acc(1, POND_ADDR_STAGE_ALT, 16'h0000);
		acc(0, POND_ADDR_STAGE_ALT, 16'h00FF);
		fire(3, 16'hA500);
		// Each group on its own channel
		acc(1, POND_ADDR_TRIG_SEL, 16'h001B);
		acc(0, POND_ADDR_TRIG_SEL, 16'h001B);
		acc(1, POND_ADDR_STAGE_HI, 16'h003C);
		acc(0, POND_ADDR_STAGE_HI, 16'h003F);
		acc(0, POND_ADDR_STAGE_ALT, 16'h00F5);
		acc(1, POND_ADDR_STAGE_ALT, 16'h00F9);
		fire(1, 16'hA900);
		fire(0, 16'h3900);
		acc(1, POND_ADDR_EN_LOW, 16'h00F0);
		fire(2, 16'h39A0);
		fire(3, 16'h39A0);
		acc(1, POND_ADDR_EN_LOW, 16'h00FF);
		fire(3, 16'h39A5);
		acc(1, POND_ADDR_EN_HIGH, 16'h000F);
		acc(1, POND_ADDR_STAGE_ALT, 16'h00F6);
		acc(1, POND_ADDR_STAGE_HI, 16'h005F);
		fire(0, 16'h39A5);
		fire(1, 16'h36A5);
		acc(1, POND_ADDR_PORT_DATA, 16'h0000);
		acc(0, POND_ADDR_PORT_DATA, 16'h06A5);
		give_verdict;
	end
endmodule
